// File: include/reset_seq_consts.svh
// Offsets, field positions, reset values and timing figures of the sequencer.
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH

// Clock period of the sequencer clock (10 MHz).
`define CLK_PERIOD_NS    100
// Internal RC tick feeding the power-up timer.
`define RC_TICK_NS       32000
// Last count of the 11-bit power-up timer (2048 ticks).
`define POWER_UP_TIMER_TICKS_LAST  11'h7ff
// Oscillator periods counted by the start-up timer.
`define OST_PERIODS      1024
// Nominal PLL lock wait.
`define PLL_LOCK_NS      2000000
// Least program-memory bias start-up time.
`define BIAS_MIN_NS      5000
// Least brown-out dip length that resets the chip.
`define BOR_MIN_NS       1000

// Register byte offsets on the APB.
`define OFF_CAUSE        32'h0000_0000
`define OFF_STACK        32'h0000_0004
`define OFF_SEQ          32'h0000_0008

// Field positions in the reset cause register.
`define CAUSE_IRQ_PRIORITY_ENABLE       7
`define CAUSE_RI         4
`define CAUSE_TO         3
`define CAUSE_PD         2
`define CAUSE_POR        1
`define CAUSE_BOR        0
`define CAUSE_POR_VAL    8'h1c
`define CAUSE_WMASK      8'h9f

// Program counter targets.
`define PC_STEP          21'h00_0002
`define VEC_HIGH         21'h00_0008
`define VEC_LOW          21'h00_0018

`endif

// File: include/reset_seq_pkg.sv
// Types shared by the reset sequencer and its bench.
package reset_seq_pkg;

   // Sequencer states.
   typedef enum logic [2:0]
   {
      ST_POR  = 3'b000,
      ST_BOR  = 3'b001,
      ST_POWER_UP_TIMER = 3'b010,
      ST_OST  = 3'b011,
      ST_PLL  = 3'b100,
      ST_BIAS = 3'b101,
      ST_RST  = 3'b110,
      ST_RUN  = 3'b111
   } seq_t;

   // Oscillator configurations.
   typedef enum logic [2:0]
   {
      OSC_LP    = 3'b000,
      OSC_XT    = 3'b001,
      OSC_HS    = 3'b010,
      OSC_HIGH_SPEED_PLL_MODE = 3'b011,
      OSC_EC    = 3'b100,
      OSC_RC    = 3'b101,
      OSC_INT   = 3'b110
   } osc_mode_t;

   // Power mode of the core.
   typedef enum logic [1:0]
   {
      MODE_RUN   = 2'b00,
      MODE_IDLE  = 2'b01,
      MODE_SLEEP = 2'b10
   } cpu_mode_t;

   // Register selected by an APB address.
   typedef enum logic [1:0]
   {
      SEL_CAUSE = 2'b00,
      SEL_STACK = 2'b01,
      SEL_SEQ   = 2'b10,
      SEL_NONE  = 2'b11
   } sel_t;

   // Configuration bits.
   typedef struct packed
   {
      logic      brownoutEnableCfg;
      logic      powerUpTimerDisableCfg;
      logic      stackFaultResetCfg;
      osc_mode_t oscMode;
   } cfg_t;

   // Core events, one-cycle pulses on the sequencer clock.
   typedef struct packed
   {
      logic watchdogExpire;
      logic stackOverflow;
      logic stackUnderflow;
      logic resetInstr;
      logic irqWake;
      logic irqHigh;
      logic highGlobalIrqEnable;
      logic lowGlobalIrqEnable;
   } evt_t;

   // APB request from the master.
   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [3:0]  pstrb;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// File: test/supply_pin_model.sv
// Model of the supply monitor, the clear pin and the crystal.
`timescale 1ns/10ps
module supply_pin_model
(
   // Sequencer clock, used only to time pin changes.
   input  logic clock,
   // Pins seen by the sequencer.
   output logic supplyLow,
   output logic masterClearPin_n,
   output logic oscClkPin
);
   // Supply good, pin released, crystal low at time zero.
   initial
   begin
      supplyLow        = 1'b0;
      masterClearPin_n = 1'b1;
      oscClkPin        = 1'b0;
   end

   // Crystal runs free, slower than half the clock and out of phase.
   always #230 oscClkPin = ~oscClkPin;

   // Supply dips below the threshold for n clock cycles.
   task automatic dip(input int n);
      supplyLow <= 1'b1;
      repeat (n) @(posedge clock);
      supplyLow <= 1'b0;
   endtask

   // Clear pin is held low for n clock cycles, then released.
   task automatic clearPin(input int n);
      masterClearPin_n <= 1'b0;
      repeat (n) @(posedge clock);
      masterClearPin_n <= 1'b1;
   endtask
endmodule // supply_pin_model

// File: test/tb_reset_timeout_cause.sv
// Self-checking bench for the reset sequencer and its cause flags.
`timescale 1ns/10ps
`include "reset_seq_consts.svh"
module tb_reset_timeout_cause;
   import reset_seq_pkg::*;
   logic        clock, nrst, supplyLow, pinN, oscClk;
   logic        coreReset, cpuStall, pcLoad, pready, pslverr;
   logic [20:0] curPc, pcValue;
   logic [31:0] prdata;
   cfg_t        cfg;
   evt_t        evt;
   cpu_mode_t   cpuMode;
   apb_req_t    apb;
   int          err_count, comparisons, t;
   logic [31:0] rdat;
   logic        serr;

   // Short counts keep the power-up wait near nine thousand cycles.
   reset_timeout_cause #(.RC_TICK_CYC(2), .PLL_LOCK_CYC(10),
      .BOR_MIN_CYC(2)) reset_timeout_cause_i (.clock(clock),
      .nrst(nrst), .supplyLow(supplyLow), .masterClearPin_n(pinN),
      .oscClkPin(oscClk), .cfg(cfg), .evt(evt), .cpuMode(cpuMode),
      .curPc(curPc), .coreReset(coreReset), .cpuStall(cpuStall),
      .pcLoad(pcLoad), .pcValue(pcValue), .apb(apb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   supply_pin_model supply_pin_model_i (.clock(clock),
      .supplyLow(supplyLow), .masterClearPin_n(pinN), .oscClkPin(oscClk));

   // Clock generator.
   always #50 clock = ~clock;

   // Compares one value and counts the outcome.
   task automatic chk(input string n, input logic [31:0] e, s);
      comparisons++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   // One APB transfer; an extra edge stops two drives in one step.
   task automatic apbx(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r, output logic se);
      int n;
      n = 0;
      apb <= '{1'b1, 1'b0, w, 4'hf, a, d};
      @(posedge clock);
      apb.penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge clock);
         n++;
      end
      r = prdata;
      se = pslverr;
      apb <= '0;
      @(posedge clock);
   endtask

   // Register read with comparison, and register write.
   task automatic rd(input logic [31:0] a, e, input string n);
      logic [31:0] r;
      logic        se;
      apbx(1'b0, a, 32'h0, r, se);
      chk(n, e, r);
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      logic        se;
      apbx(1'b1, a, d, r, se);
   endtask

   // One-cycle core event pulse.
   task automatic ev(input evt_t e);
      evt <= e;
      @(posedge clock);
      evt <= '0;
   endtask

   // Waits for the program counter load and checks its target.
   task automatic waitLoad(input logic [20:0] e, input string n);
      t = 0;
      do
      begin
         @(posedge clock);
         t++;
      end
      while (pcLoad !== 1'b1 && t < 20000);
      chk(n, {10'h0, 1'b1, e}, {10'h0, pcLoad, pcValue});
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Cuts a hang short at about twice the expected run length.
   initial
   begin
      #8_000_000;
      err_count++;
      results;
   end

   // Main sequence; evt codes: 80 watchdog, 40/20 stack, 08 wake.
   initial
   begin
      clock = 1'b0;
      nrst = 1'b0;
      apb = '0;
      evt = '0;
      cpuMode = MODE_RUN;
      curPc = 21'h00_0100;
      cfg = '{1'b0, 1'b0, 1'b1, OSC_HS};
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      waitLoad(21'h0, "pc power-up");
      chk("power-up span", 1, t >= 8192 && t < 9500);
      rd(`OFF_CAUSE, 32'h1c, "cause power-on");
      rd(`OFF_STACK, 32'h0, "stack power-on");
      wr(`OFF_CAUSE, 32'hff);
      rd(`OFF_CAUSE, 32'h9f, "cause layout");
      rd(32'h40, 32'h0, "unmapped read");
      apbx(1'b0, 32'h40, 32'h0, rdat, serr);
      chk("unmapped error", 1, serr);
      $display("test power-up done");
      ev(8'h80);
      waitLoad(21'h0, "pc watchdog run");
      rd(`OFF_CAUSE, 32'h97, "cause watchdog run");
      wr(`OFF_CAUSE, 32'h80);
      supply_pin_model_i.clearPin(5);
      waitLoad(21'h0, "pc clear run");
      rd(`OFF_CAUSE, 32'h88, "cause clear run");
      wr(`OFF_CAUSE, 32'h84);
      cpuMode <= MODE_SLEEP;
      supply_pin_model_i.clearPin(5);
      waitLoad(21'h0, "pc clear sleep");
      rd(`OFF_CAUSE, 32'h88, "cause clear sleep");
      $display("test clear and watchdog done");
      wr(`OFF_CAUSE, 32'h9c);
      ev(8'h80);
      repeat (3) @(posedge clock);
      chk("stall in wake", 1, cpuStall);
      waitLoad(21'h102, "pc watchdog sleep");
      rd(`OFF_CAUSE, 32'h90, "cause watchdog sleep");
      wr(`OFF_CAUSE, 32'h9c);
      ev(8'h0e);
      waitLoad(21'h008, "pc high vector");
      rd(`OFF_CAUSE, 32'h98, "cause irq wake");
      ev(8'h09);
      waitLoad(21'h018, "pc low vector");
      curPc <= 21'h00_0200;
      ev(8'h08);
      waitLoad(21'h202, "pc plain wake");
      cpuMode <= MODE_RUN;
      $display("test wake done");
      ev(8'h40);
      waitLoad(21'h0, "pc stack reset");
      rd(`OFF_STACK, 32'h1, "stack overflow");
      wr(`OFF_STACK, 32'h0);
      cfg.stackFaultResetCfg <= 1'b0;
      ev(8'h20);
      repeat (5) @(posedge clock);
      chk("no stack reset", 0, coreReset);
      rd(`OFF_STACK, 32'h2, "stack underflow");
      rd(`OFF_CAUSE, 32'h98, "cause kept");
      $display("test stack done");
      supply_pin_model_i.dip(20);
      repeat (5) @(posedge clock);
      chk("brown-out off", 0, coreReset);
      cfg.brownoutEnableCfg <= 1'b1;
      wr(`OFF_CAUSE, 32'h01);
      supply_pin_model_i.dip(20);
      chk("brown-out on", 1, coreReset);
      repeat (2000) @(posedge clock);
      supply_pin_model_i.dip(20);
      waitLoad(21'h0, "pc brown-out");
      chk("brown-out span", 1, t >= 8192 && t < 9500);
      rd(`OFF_CAUSE, 32'h1c, "cause brown-out");
      $display("test brown-out done");
      // Second power-on: no power-up timer, pin held past every wait.
      nrst <= 1'b0;
      cfg <= '{1'b1, 1'b1, 1'b1, OSC_EC};
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      supply_pin_model_i.clearPin(200);
      waitLoad(21'h0, "pc late clear release");
      chk("late release span", 1, t < 8);
      rd(`OFF_CAUSE, 32'h1c, "cause second power-on");
      // Third power-on: PLL mode adds the lock wait after the count.
      nrst <= 1'b0;
      cfg <= '{1'b1, 1'b1, 1'b1, OSC_HIGH_SPEED_PLL_MODE};
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      waitLoad(21'h0, "pc pll power-up");
      chk("pll span", 1, t >= 4700 && t < 4800);
      $display("test second power-up done");
      results;
   end
endmodule // tb_reset_timeout_cause

// File: verilog/reset_timeout_cause.sv
// Reset time-out sequencer with reset-cause flags and an APB slave.
`timescale 1ns/10ps
`include "reset_seq_consts.svh"
module reset_timeout_cause
#(
   parameter int RC_TICK_CYC  = `RC_TICK_NS / `CLK_PERIOD_NS,
   parameter int PLL_LOCK_CYC = `PLL_LOCK_NS / `CLK_PERIOD_NS,
   parameter int BOR_MIN_CYC  = `BOR_MIN_NS / `CLK_PERIOD_NS
)
(
   // Clock and power-on reset.
   input  logic                    clock,
   input  logic                    nrst,
   // Asynchronous pins.
   input  logic                    supplyLow,
   input  logic                    masterClearPin_n,
   input  logic                    oscClkPin,
   // Configuration and core side.
   input  reset_seq_pkg::cfg_t      cfg,
   input  reset_seq_pkg::evt_t      evt,
   input  reset_seq_pkg::cpu_mode_t cpuMode,
   input  logic [20:0]             curPc,
   output logic                    coreReset,
   output logic                    cpuStall,
   output logic                    pcLoad,
   output logic [20:0]             pcValue,
   // APB slave.
   input  reset_seq_pkg::apb_req_t  apb,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr
);
   import reset_seq_pkg::*;

   localparam int BIAS_CYC =
      (`BIAS_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   // Whole state of the block.
   typedef struct packed
   {
      seq_t        seq;
      logic        wakeSeq;
      logic [15:0] cnt;
      logic [15:0] rcDiv;
      logic [10:0] pwrtCnt;
      logic [15:0] borCnt;
      logic        supS1;
      logic        supS2;
      logic        mclrS1;
      logic        mclrS2;
      logic        mclrPrev;
      logic        oscS1;
      logic        oscS2;
      logic        oscS3;
      logic [7:0]  cause;
      logic        stack_overflow_flag;
      logic        stack_underflow_flag;
      logic [31:0] prdata;
      logic [20:0] pcValue;
      logic        pcLoad;
      logic        coreRst;
      logic        stall;
   } state_t;

   localparam state_t RESET_STATE = '{
      seq:      ST_POR,
      cause:    `CAUSE_POR_VAL,
      mclrS1:   1'b1,
      mclrS2:   1'b1,
      mclrPrev: 1'b1,
      coreRst:  1'b1,
      default:  '0
   };

   state_t q;
   state_t d;
   logic   borHit;
   logic   rcTick;
   logic   oscEdge;
   logic   inRun;
   logic   asleep;
   logic   wrEn;
   logic   evMclr;
   logic   evStkRst;
   logic   evStkErr;
   logic   evWdtRun;
   logic   evRstInstr;
   logic   evWdtWake;
   logic   evIrqWake;

   // Maps an APB byte address onto a register.
   function automatic sel_t reg_sel(input logic [31:0] a);
      sel_t s;
      s = SEL_NONE;
      if (a == `OFF_CAUSE)
      begin
         s = SEL_CAUSE;
      end
      else if (a == `OFF_STACK)
      begin
         s = SEL_STACK;
      end
      else if (a == `OFF_SEQ)
      begin
         s = SEL_SEQ;
      end
      return s;
   endfunction

   // Picks the wait that follows the power-up delay or starts a wake.
   function automatic seq_t next_timer(input osc_mode_t m,
                                       input logic pwrtRan);
      seq_t s;
      if (m == OSC_LP || m == OSC_XT || m == OSC_HS || m == OSC_HIGH_SPEED_PLL_MODE)
      begin
         s = ST_OST;
      end
      else if (pwrtRan)
      begin
         s = ST_RUN;
      end
      else
      begin
         s = ST_BIAS;
      end
      return s;
   endfunction

   // Zero-wait slave; only unmapped addresses raise an error.
   assign pready    = 1'b1;
   assign pslverr   = apb.psel && apb.penable &&
                      (reg_sel(apb.paddr) == SEL_NONE);
   assign prdata    = q.prdata;
   assign coreReset = q.coreRst;
   assign cpuStall  = q.stall;
   assign pcLoad    = q.pcLoad;
   assign pcValue   = q.pcValue;

   // Next-state logic of the whole block.
   always_comb
   begin
      d          = q;
      d.pcLoad   = 1'b0;
      evMclr     = 1'b0;
      evStkRst   = 1'b0;
      evStkErr   = 1'b0;
      evWdtRun   = 1'b0;
      evRstInstr = 1'b0;
      evWdtWake  = 1'b0;
      evIrqWake  = 1'b0;

      // Pins cross into the clock domain through two flops each.
      d.supS1  = supplyLow;
      d.supS2  = q.supS1;
      d.mclrS1 = masterClearPin_n;
      d.mclrS2 = q.mclrS1;
      d.mclrPrev = q.mclrS2;
      d.oscS1  = oscClkPin;
      d.oscS2  = q.oscS1;
      d.oscS3  = q.oscS2;
      oscEdge  = q.oscS2 & ~q.oscS3;

      // A dip must outlast the least time; shorter ones are ignored.
      if (cfg.brownoutEnableCfg && q.supS2)
      begin
         if (q.borCnt != 16'(BOR_MIN_CYC))
         begin
            d.borCnt = q.borCnt + 16'h0001;
         end
      end
      else
      begin
         d.borCnt = 16'h0000;
      end
      borHit = cfg.brownoutEnableCfg && q.supS2 &&
               (q.borCnt == 16'(BOR_MIN_CYC));

      // The RC tick divider only runs while the power-up delay runs.
      rcTick = (q.rcDiv == 16'(RC_TICK_CYC - 1));

      // Software writes first, so hardware events below win.
      wrEn = apb.psel && apb.penable && apb.pwrite && apb.pstrb[0];
      if (wrEn && reg_sel(apb.paddr) == SEL_CAUSE)
      begin
         d.cause = apb.pwdata[7:0] & `CAUSE_WMASK;
      end
      if (wrEn && reg_sel(apb.paddr) == SEL_STACK)
      begin
         d.stack_overflow_flag = apb.pwdata[0];
         d.stack_underflow_flag = apb.pwdata[1];
      end

      // Read data is captured in the setup phase for the access phase.
      if (apb.psel && !apb.penable)
      begin
         case (reg_sel(apb.paddr))
            SEL_CAUSE: d.prdata = {24'h000000, q.cause};
            SEL_STACK: d.prdata = {30'h00000000, q.stack_underflow_flag, q.stack_overflow_flag};
            SEL_SEQ:   d.prdata = {27'h0000000, q.coreRst, q.wakeSeq,
                                   q.seq};
            default:   d.prdata = 32'h00000000;
         endcase
      end

      // Time-out chain; it runs whatever the clear pin does.
      case (q.seq)
         ST_POR:
         begin
            if (!cfg.powerUpTimerDisableCfg)
            begin
               d.seq = ST_POWER_UP_TIMER;
            end
            else
            begin
               d.seq = next_timer(cfg.oscMode, 1'b0);
            end
         end
         ST_BOR:
         begin
            if (!q.supS2)
            begin
               d.seq = !cfg.powerUpTimerDisableCfg ? ST_POWER_UP_TIMER :
                       next_timer(cfg.oscMode, 1'b0);
            end
         end
         ST_POWER_UP_TIMER:
         begin
            d.rcDiv = rcTick ? 16'h0000 : q.rcDiv + 16'h0001;
            if (rcTick)
            begin
               d.pwrtCnt = q.pwrtCnt + 11'h001;
               if (q.pwrtCnt == `POWER_UP_TIMER_TICKS_LAST)
               begin
                  d.seq = next_timer(cfg.oscMode, 1'b1);
               end
            end
         end
         ST_OST:
         begin
            if (oscEdge)
            begin
               d.cnt = q.cnt + 16'h0001;
               if (q.cnt == 16'(`OST_PERIODS - 1))
               begin
                  d.seq = (cfg.oscMode == OSC_HIGH_SPEED_PLL_MODE) ? ST_PLL : ST_RUN;
               end
            end
         end
         ST_PLL:
         begin
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(PLL_LOCK_CYC - 1))
            begin
               d.seq = ST_RUN;
            end
         end
         ST_BIAS:
         begin
            d.cnt = q.cnt + 16'h0001;
            if (q.cnt == 16'(BIAS_CYC - 1))
            begin
               d.seq = ST_RUN;
            end
         end
         ST_RST:
         begin
            d.seq = ST_RUN;
         end
         ST_RUN:
         begin
            d.seq = ST_RUN;
         end
         default:
         begin
            d.seq = ST_POR;
         end
      endcase

      // Event arbitration: brown-out first, then the clear pin.
      inRun  = (q.seq == ST_RUN) && !q.wakeSeq;
      asleep = inRun && (cpuMode != MODE_RUN);
      if (!(borHit && q.seq != ST_BOR))
      begin
         if (q.mclrPrev && !q.mclrS2 && q.seq == ST_RUN)
         begin
            evMclr = 1'b1;
         end
         else if (inRun)
         begin
            if ((evt.stackOverflow || evt.stackUnderflow) &&
                cfg.stackFaultResetCfg)
            begin
               evStkRst = 1'b1;
            end
            else if (evt.watchdogExpire && !asleep)
            begin
               evWdtRun = 1'b1;
            end
            else if (evt.resetInstr && !asleep)
            begin
               evRstInstr = 1'b1;
            end
            else if (evt.watchdogExpire && asleep)
            begin
               evWdtWake = 1'b1;
            end
            else if (evt.irqWake && asleep)
            begin
               evIrqWake = 1'b1;
            end
         end
      end
      evStkErr = inRun && evt.stackUnderflow && !cfg.stackFaultResetCfg;

      // Stack flags are set by any fault while executing.
      if (inRun && evt.stackOverflow)
      begin
         d.stack_overflow_flag = 1'b1;
      end
      if (inRun && evt.stackUnderflow)
      begin
         d.stack_underflow_flag = 1'b1;
      end

      // Cause flags and program counter for each event.
      if (borHit && q.seq != ST_BOR)
      begin
         d.seq                = ST_BOR;
         d.wakeSeq            = 1'b0;
         d.pcValue            = 21'h000000;
         d.cause[`CAUSE_RI]   = 1'b1;
         d.cause[`CAUSE_TO]   = 1'b1;
         d.cause[`CAUSE_PD]   = 1'b1;
         d.cause[`CAUSE_BOR]  = 1'b0;
      end
      else if (evMclr)
      begin
         d.pcValue          = 21'h000000;
         d.cause[`CAUSE_TO] = 1'b1;
         if (cpuMode != MODE_RUN)
         begin
            d.cause[`CAUSE_PD] = 1'b0;
         end
      end
      else if (evStkRst || evRstInstr)
      begin
         d.seq     = ST_RST;
         d.pcValue = 21'h000000;
         if (evRstInstr)
         begin
            d.cause[`CAUSE_RI] = 1'b0;
         end
      end
      else if (evWdtRun)
      begin
         d.seq              = ST_RST;
         d.pcValue          = 21'h000000;
         d.cause[`CAUSE_TO] = 1'b0;
      end
      else if (evWdtWake || evIrqWake)
      begin
         d.seq              = next_timer(cfg.oscMode, 1'b0);
         d.wakeSeq          = 1'b1;
         d.cause[`CAUSE_PD] = 1'b0;
         d.pcValue          = curPc + `PC_STEP;
         if (evWdtWake)
         begin
            d.cause[`CAUSE_TO] = 1'b0;
         end
         else if (evt.irqHigh && evt.highGlobalIrqEnable)
         begin
            d.pcValue = `VEC_HIGH;
         end
         else if (evt.lowGlobalIrqEnable)
         begin
            d.pcValue = `VEC_LOW;
         end
      end

      // Every wait starts from zero, so a re-entered delay runs in full.
      if (d.seq != q.seq)
      begin
         d.cnt     = 16'h0000;
         d.rcDiv   = 16'h0000;
         d.pwrtCnt = 11'h000;
      end
      if (d.seq == ST_RUN)
      begin
         d.wakeSeq = 1'b0;
      end

      // Reset holds through every wait except those of a wake; a late pin release runs at once.
      d.coreRst = ((d.seq != ST_RUN) && !d.wakeSeq) ||
                  !q.mclrS2;
      d.stall   = d.wakeSeq;
      d.pcLoad  = (q.coreRst && !d.coreRst) ||
                  (q.wakeSeq && !d.wakeSeq);
   end

   // State register; power-on reset loads the cause reset value.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         q <= RESET_STATE;
      end
      else
      begin
         q <= d;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_bor_off;
      !cfg.brownoutEnableCfg && q.seq != ST_BOR |=> q.seq != ST_BOR;
   endproperty
   a_bor_off: assert property (p_bor_off)
      else $error("brown-out entered while disabled");

   property p_bor_entry;
      borHit && q.seq != ST_BOR |=> q.seq == ST_BOR &&
         q.cause[4:2] == 3'b111 && !q.cause[`CAUSE_BOR];
   endproperty
   a_bor_entry: assert property (p_bor_entry)
      else $error("brown-out entry flags wrong");

   property p_bor_hold;
      q.seq == ST_BOR |-> q.coreRst;
   endproperty
   a_bor_hold: assert property (p_bor_hold)
      else $error("core released during brown-out");

   property p_power_up_timer_retry;
      q.seq == ST_POWER_UP_TIMER && borHit |=> q.seq == ST_BOR &&
         q.pwrtCnt == 11'h000;
   endproperty
   a_power_up_timer_retry: assert property (p_power_up_timer_retry)
      else $error("power-up delay not restarted");

   property p_power_up_timer_end;
      q.seq == ST_POWER_UP_TIMER && rcTick && !borHit &&
         q.pwrtCnt == `POWER_UP_TIMER_TICKS_LAST |=> q.seq != ST_POWER_UP_TIMER;
   endproperty
   a_power_up_timer_end: assert property (p_power_up_timer_end)
      else $error("power-up delay overran");

   property p_master_clear_pin;
      evMclr |=> q.cause[`CAUSE_TO] && q.pcValue == 21'h000000 &&
         q.coreRst;
   endproperty
   a_master_clear_pin: assert property (p_master_clear_pin)
      else $error("clear pin reset wrong");

   property p_wdt_run;
      evWdtRun |=> !q.cause[`CAUSE_TO] && q.seq == ST_RST && q.coreRst;
   endproperty
   a_wdt_run: assert property (p_wdt_run)
      else $error("watchdog reset wrong");

   property p_wdt_wake;
      evWdtWake |=> q.cause[3:2] == 2'b00 && q.wakeSeq &&
         q.pcValue == $past(curPc) + `PC_STEP;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake)
      else $error("watchdog wake wrong");

   property p_vec;
      evIrqWake && evt.irqHigh && evt.highGlobalIrqEnable
         |=> q.pcValue == `VEC_HIGH && !q.cause[`CAUSE_PD];
   endproperty
   a_vec: assert property (p_vec)
      else $error("high vector not loaded");

   property p_stk;
      evStkErr && !borHit && !evMclr |=> q.stack_underflow_flag &&
         $stable(q.cause[4:0]);
   endproperty
   a_stk: assert property (p_stk)
      else $error("stack underflow error handled wrong");

endmodule // reset_timeout_cause
